// [logic/sop_map.vh]
// Constants for the spindle orientation position block
`ifndef SOP_MAP_VH
`define SOP_MAP_VH
`define SOP_STEPS_PER_TURN 4096
`define SOP_ANGLE_W        12
`define SOP_ANGLE_MAX      12'hfff
`define SOP_ANGLE_RST      12'h000
`define SOP_OFFSET_RST     12'h000
`define SOP_TOL_DEFAULT    12'h002
`define SOP_BCD_HUND_MSB   11
`define SOP_BCD_HUND_LSB   8
`define SOP_BCD_TENS_MSB   7
`define SOP_BCD_TENS_LSB   4
`define SOP_BCD_ONES_MSB   3
`define SOP_BCD_ONES_LSB   0
`define SOP_SYNC_RST       2'h0
`define SOP_PRIME_RST      2'h0
`define SOP_PRIME_CNT      2'h3
`endif

// [logic/sop_sync.v]
// Two-flop synchroniser for one encoder channel
`timescale 1ns/1ns
module sop_sync (
  input  wire sys_clk_i, // Control clock
  input  wire rst_b_i,   // Async reset, active low
  input  wire d_i,       // Asynchronous level
  output wire q_o        // Synchronised level
);
  reg meta_reg;
  reg sync_reg;

  // Only the second stage is visible to logic
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule

// [logic/sop_orient.v]
// Spindle orientation: encoder angle, index origin, stop reference compare
//
// Contract
// - One turn equals 4096 angle steps
// - Stop reference in binary or BCD
// - Angle from quadrature and index channels
// - Origin is offset pulses after index rise
// - Target from internal setting or external
// - Motor encoder selectable as position source
`timescale 1ns/1ns
`include "sop_map.vh"
module sop_orient #(
  parameter ANGLE_W = `SOP_ANGLE_W // Angle width, 4096 steps per turn
) (
  input  wire               sys_clk_i,     // 20 MHz control clock
  input  wire               rst_b_i,       // Async reset, active low
  input  wire               load_a_i,      // Load-shaft encoder channel A
  input  wire               load_b_i,      // Load-shaft encoder channel B
  input  wire               load_z_i,      // Load-shaft encoder index
  input  wire               mot_a_i,       // Motor encoder channel A
  input  wire               mot_b_i,       // Motor encoder channel B
  input  wire               mot_z_i,       // Motor encoder index
  input  wire               src_motor_i,   // 1: use motor encoder (1:1 coupling only)
  input  wire               ref_ext_i,     // 1: external reference, 0: internal
  input  wire               ref_bcd_i,     // 1: external reference is 3-digit BCD
  input  wire [ANGLE_W-1:0] ref_ext_val_i, // External stop reference
  input  wire [ANGLE_W-1:0] ref_int_val_i, // Internal stop setting
  input  wire [ANGLE_W-1:0] offset_i,      // Origin offset pulses
  input  wire [ANGLE_W-1:0] tol_i,         // In-position window, steps
  output reg  [ANGLE_W-1:0] angle_o,       // Shaft angle relative to origin
  output reg  [ANGLE_W-1:0] target_o,      // Selected binary target angle
  output reg  [ANGLE_W-1:0] error_o,       // Target minus angle, modulo turn
  output reg                origin_ok_o,   // Origin established since reset
  output reg                in_pos_o,      // Angle within window of target
  output reg                ref_bad_o      // BCD reference has a digit above nine
);
  // Synchronised encoder channels
  wire la_s; // Load A
  wire lb_s; // Load B
  wire lz_s; // Load index
  wire ma_s; // Motor A
  wire mb_s; // Motor B
  wire mz_s; // Motor index

  // Every encoder channel crosses in through two flops
  // Load-shaft channels
  sop_sync u_la (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       (load_a_i),
    .q_o       (la_s)
  );
  sop_sync u_lb (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       (load_b_i),
    .q_o       (lb_s)
  );
  sop_sync u_lz (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       (load_z_i),
    .q_o       (lz_s)
  );

  // Motor channels
  sop_sync u_ma (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       (mot_a_i),
    .q_o       (ma_s)
  );
  sop_sync u_mb (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       (mot_b_i),
    .q_o       (mb_s)
  );
  sop_sync u_mz (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       (mot_z_i),
    .q_o       (mz_s)
  );

  // source select
  // Motor source is only valid when coupled 1:1 without play
  wire a_s = src_motor_i ? ma_s : la_s;
  wire b_s = src_motor_i ? mb_s : lb_s;
  wire z_s = src_motor_i ? mz_s : lz_s;

  reg               a_d_reg;
  reg               b_d_reg;
  reg               z_d_reg;
  reg [ANGLE_W-1:0] raw_reg;
  reg [ANGLE_W-1:0] raw_next;
  reg               fwd_reg;
  reg               fwd_next;
  reg [1:0]         prime_reg;

  // decode settle
  // Synchronisers and history flops all reset low, so the first real pin
  // levels would look like edges; decoding waits until the history holds them
  wire primed = (prime_reg == `SOP_PRIME_CNT);

  // Count three edges after reset, then stay
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prime_reg <= `SOP_PRIME_RST;
    end else if (!primed) begin
      prime_reg <= prime_reg + 2'h1;
    end
  end

  // quadrature step
  // Any edge on A or B is one count; direction from the old/new phase pair
  // Both channels moving in one sample is a skipped state and is not counted
  wire a_ch = a_s ^ a_d_reg;
  wire b_ch = b_s ^ b_d_reg;
  wire step = primed & (a_ch ^ b_ch);
  wire up   = a_d_reg ^ b_s;
  wire z_rise = primed & z_s & ~z_d_reg;

  always @* begin
    raw_next = raw_reg;
    fwd_next = fwd_reg;
    if (step) begin
      fwd_next = up;
      if (up) begin
        raw_next = raw_reg + {{(ANGLE_W-1){1'b0}}, 1'b1};
      end else begin
        raw_next = raw_reg - {{(ANGLE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      a_d_reg <= 1'b0;
      b_d_reg <= 1'b0;
      z_d_reg <= 1'b0;
      raw_reg <= `SOP_ANGLE_RST;
      fwd_reg <= 1'b1;
    end else begin
      a_d_reg <= a_s;
      b_d_reg <= b_s;
      z_d_reg <= z_s;
      fwd_reg <= fwd_next;
      // index rise in forward turn
      // Forward index rise re-zeroes the count so origin is offset pulses later
      if (z_rise && fwd_next) begin
        raw_reg <= `SOP_ANGLE_RST;
      end else begin
        raw_reg <= raw_next;
      end
    end
  end

  // BCD decode
  // Three BCD digits give 0..999, which fits in the 12-bit target
  wire [3:0] d_h = ref_ext_val_i[`SOP_BCD_HUND_MSB:`SOP_BCD_HUND_LSB];
  wire [3:0] d_t = ref_ext_val_i[`SOP_BCD_TENS_MSB:`SOP_BCD_TENS_LSB];
  wire [3:0] d_o = ref_ext_val_i[`SOP_BCD_ONES_MSB:`SOP_BCD_ONES_LSB];
  // Hundreds times 100 as 64 + 32 + 4, tens times 10 as 8 + 2; shifts, no multiplier
  wire [13:0] h_64    = {4'h0, d_h, 6'h00};
  wire [13:0] h_32    = {5'h00, d_h, 5'h00};
  wire [13:0] h_4     = {8'h00, d_h, 2'h0};
  wire [13:0] t_8     = {7'h00, d_t, 3'h0};
  wire [13:0] t_2     = {9'h000, d_t, 1'h0};
  wire [13:0] o_1     = {10'h000, d_o};
  wire [13:0] bcd_bin = h_64 + h_32 + h_4 + t_8 + t_2 + o_1;
  wire bcd_bad = (d_h > 4'h9) | (d_t > 4'h9) | (d_o > 4'h9);

  reg [ANGLE_W-1:0] tgt_next;
  reg               bad_next;

  // target select
  // A bad BCD value holds the previous target rather than chase garbage
  always @* begin
    tgt_next = target_o;
    bad_next = 1'b0;
    if (!ref_ext_i) begin
      tgt_next = ref_int_val_i;
    end else if (!ref_bcd_i) begin
      tgt_next = ref_ext_val_i;
    end else if (bcd_bad) begin
      bad_next = 1'b1;
    end else begin
      tgt_next = bcd_bin[ANGLE_W-1:0];
    end
  end

  // Angle from origin, and the distance to target taken both ways round
  // the turn; within the window either way counts as in position
  wire [ANGLE_W-1:0] ang_now = raw_reg - offset_i;
  wire [ANGLE_W-1:0] err_now = target_o - angle_o;
  wire [ANGLE_W-1:0] err_neg = angle_o - target_o;

  // Registered outputs; compare lags the angle by one cycle
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      angle_o     <= `SOP_ANGLE_RST;
      target_o    <= `SOP_ANGLE_RST;
      error_o     <= `SOP_ANGLE_RST;
      origin_ok_o <= 1'b0;
      in_pos_o    <= 1'b0;
      ref_bad_o   <= 1'b0;
    end else begin
      angle_o   <= ang_now;
      target_o  <= tgt_next;
      error_o   <= err_now;
      ref_bad_o <= bad_next;
      if (z_rise && fwd_next) begin
        origin_ok_o <= 1'b1;
      end
      in_pos_o <= origin_ok_o & ((err_now <= tol_i) | (err_neg <= tol_i));
    end
  end
endmodule

// [tb/sop_orient_checker.sv]
// Port checker for the orientation block
`timescale 1ns/1ns
module sop_orient_chk (
  input wire        sys_clk_i, rst_b_i, ref_ext_i, ref_bcd_i,
  input wire        load_a_i, load_b_i, load_z_i, mot_a_i, mot_b_i, mot_z_i,
  input wire [11:0] ref_ext_val_i, ref_int_val_i, offset_i, angle_o, target_o, error_o,
  input wire        origin_ok_o, in_pos_o, ref_bad_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // BCD digits; a digit above nine is refused
  wire [3:0]  hd = ref_ext_val_i[11:8], td = ref_ext_val_i[7:4], od = ref_ext_val_i[3:0];
  wire [11:0] dec = hd * 12'h064 + td * 12'h00a + od;
  wire        bcd = ref_ext_i & ref_bcd_i;
  wire        bin = ref_ext_i & !ref_bcd_i;
  wire        bad = hd > 4'h9 || td > 4'h9 || od > 4'h9;
  // Six quiet samples outlast the sync and count stages
  sequence quiet;
    $stable({load_a_i, load_b_i, load_z_i, mot_a_i, mot_b_i, mot_z_i, offset_i}) [*6];
  endsequence
  hold_angle_a: assert property (quiet |-> $stable(angle_o))
    else $error("angle drift");
  error_diff_a: assert property (1 |=> error_o == $past(target_o) - $past(angle_o))
    else $error("error wrong");
  int_target_a: assert property (!ref_ext_i |=> target_o == $past(ref_int_val_i))
    else $error("internal target");
  bin_target_a: assert property (bin |=> target_o == $past(ref_ext_val_i))
    else $error("binary target");
  bcd_target_a: assert property (bcd && !bad |=> target_o == $past(dec) && !ref_bad_o)
    else $error("BCD target");
  bcd_refuse_a: assert property (bcd && bad |=> ref_bad_o && $stable(target_o))
    else $error("bad BCD taken");
  origin_keep_a: assert property (origin_ok_o |=> origin_ok_o)
    else $error("origin lost");
  pos_origin_a: assert property (in_pos_o |-> origin_ok_o)
    else $error("early in position");
endmodule

// [tb/sop_enc_model.sv]
// Encoder model with quadrature and index
`timescale 1ns/1ns
module sop_enc (
  input  wire sys_clk_i, // Clock
  output wire a_o,       // Channel A
  output wire b_o,       // Channel B
  output wire z_o        // Index
);
  reg [11:0] pos_reg = 12'h064; // Starts away from index
  assign a_o = pos_reg[1];
  assign b_o = pos_reg[1] ^ pos_reg[0];
  assign z_o = pos_reg[11:2] == 10'h000;
  // Three clocks per edge keeps the spacing legal; B leads forward
  task step(input up);
    repeat (3) @(posedge sys_clk_i);
    #5 pos_reg = up ? pos_reg + 12'h001 : pos_reg - 12'h001;
  endtask
endmodule

// [tb/sop_orient_tb.sv]
// Bench for the spindle orientation block
`timescale 1ns/1ns
module sop_orient_tb;
  reg         sys_clk_i = 0, rst_b_i = 0, src_motor_i = 0, ref_ext_i = 0, ref_bcd_i = 0;
  reg  [11:0] ref_ext_val_i = 12'h000, ref_int_val_i = 12'h000;
  reg  [11:0] offset_i = 12'h005, tol_i = 12'h002;
  wire        load_a_i, load_b_i, load_z_i, mot_a_i, mot_b_i, mot_z_i;
  wire        origin_ok_o, in_pos_o, ref_bad_o;
  wire [11:0] angle_o, target_o, error_o;
  integer     mismatches = 0, check_count = 0, i;
  // 20 MHz clock
  always #25 sys_clk_i = ~sys_clk_i;
  sop_enc ld (.sys_clk_i(sys_clk_i), .a_o(load_a_i), .b_o(load_b_i), .z_o(load_z_i));
  sop_enc mo (.sys_clk_i(sys_clk_i), .a_o(mot_a_i), .b_o(mot_b_i), .z_o(mot_z_i));
  sop_orient dut (
    .sys_clk_i     (sys_clk_i),
    .rst_b_i       (rst_b_i),
    .load_a_i      (load_a_i),
    .load_b_i      (load_b_i),
    .load_z_i      (load_z_i),
    .mot_a_i       (mot_a_i),
    .mot_b_i       (mot_b_i),
    .mot_z_i       (mot_z_i),
    .src_motor_i   (src_motor_i),
    .ref_ext_i     (ref_ext_i),
    .ref_bcd_i     (ref_bcd_i),
    .ref_ext_val_i (ref_ext_val_i),
    .ref_int_val_i (ref_int_val_i),
    .offset_i      (offset_i),
    .tol_i         (tol_i),
    .angle_o       (angle_o),
    .target_o      (target_o),
    .error_o       (error_o),
    .origin_ok_o   (origin_ok_o),
    .in_pos_o      (in_pos_o),
    .ref_bad_o     (ref_bad_o)
  );
  task chk(input [11:0] got, exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("%0d mismatches, %0d checks", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Source is only changed under reset, as it is not synchronised
  task rst(input m);
    rst_b_i = 0;
    src_motor_i = m;
    repeat (16) @(posedge sys_clk_i);
    #5 rst_b_i = 1;
  endtask
  task spin(input m, up, input integer n);
    for (i = 0; i < n; i = i + 1)
      if (m) mo.step(up);
      else ld.step(up);
    repeat (6) @(posedge sys_clk_i);
    #5;
  endtask
  task set(input e, b, input [11:0] v, w);
    {ref_ext_i, ref_bcd_i, ref_ext_val_i, ref_int_val_i} = {e, b, v, w};
    repeat (3) @(posedge sys_clk_i);
    #5;
  endtask
  task t_origin;
    chk(origin_ok_o, 0);
    spin(0, 1, 4006);
    chk(origin_ok_o, 1);
    chk(angle_o, 12'h005);
    spin(0, 0, 20);
    chk(angle_o, 12'hff1);
    $display("origin test done");
  endtask
  task t_ref;
    set(1, 1, 12'h359, 12'hff3);
    chk(target_o, 12'h167);
    set(1, 1, 12'h3a1, 12'hff3);
    chk({target_o[10:0], ref_bad_o}, 12'h2cf);
    set(1, 0, 12'h3a1, 12'hff3);
    chk(target_o, 12'h3a1);
    set(0, 0, 12'h3a1, 12'hff3);
    chk({error_o[10:0], in_pos_o}, 12'h005);
    set(0, 0, 12'h3a1, 12'hff4);
    chk(in_pos_o, 0);
    $display("reference test done");
  endtask
  // Motor source; the load encoder then moves without effect, and a new offset shifts the origin
  task t_motor;
    rst(1);
    chk(origin_ok_o, 0);
    spin(1, 1, 4003);
    chk(angle_o, 12'h002);
    chk(origin_ok_o, 1);
    spin(0, 1, 8);
    chk(angle_o, 12'h002);
    offset_i = 12'h000;
    repeat (2) @(posedge sys_clk_i);
    #5;
    chk(angle_o, 12'h007);
    $display("motor test done");
  endtask
  initial begin
    rst(0);
    t_origin;
    t_ref;
    t_motor;
    print_verdict;
  end
  // Run needs about 1.2 ms
  initial begin
    #3000000;
    mismatches = mismatches + 1;
    $display("Error %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule
bind sop_orient sop_orient_chk u_chk (
  .sys_clk_i     (sys_clk_i),
  .rst_b_i       (rst_b_i),
  .ref_ext_i     (ref_ext_i),
  .ref_bcd_i     (ref_bcd_i),
  .load_a_i      (load_a_i),
  .load_b_i      (load_b_i),
  .load_z_i      (load_z_i),
  .mot_a_i       (mot_a_i),
  .mot_b_i       (mot_b_i),
  .mot_z_i       (mot_z_i),
  .ref_ext_val_i (ref_ext_val_i),
  .ref_int_val_i (ref_int_val_i),
  .offset_i      (offset_i),
  .angle_o       (angle_o),
  .target_o      (target_o),
  .error_o       (error_o),
  .origin_ok_o   (origin_ok_o),
  .in_pos_o      (in_pos_o),
  .ref_bad_o     (ref_bad_o)
);
